// ### hdl/ssm_consts.vh
// Constants for the switchgear object status monitor
// Functional notes
// R01 - Neither breaker position input active reports breaker intermediate.
// R02 - Both breaker position inputs active reports breaker bad.
// R03 - Only open input gives open; only closed input gives closed.
// R04 - Neither cart input active reports cart midway.
// R05 - Both cart inputs active reports cart fault.
// R06 - Non-withdrawable object types report cart not in use, cart inputs ignored.
// R07 - Synchrocheck enabled refuses close without permission; disabled by default.
// R08 - Permission comes from internal synchrocheck signal or external digital input.
// R09 - Ready check high or low gates close; not in use ignores input.
// R10 - Two 32-bit unsigned counters of successful open and close requests.
// R11 - Two 32-bit unsigned counters of failed open and close requests.
// R12 - Clear command zeroes all four counters, then returns to idle itself; a request counted in the clearing cycle leaves its counter at one.
// R13 - Object type, default circuit breaker, selects monitored inputs and cart supervision.
// R14 - Withdrawable breaker: cart, position, control, ready, synchrocheck and interlocks.
// R15 - Circuit breaker: position, control, ready, synchrocheck, interlocks, no cart.
// R16 - Main disconnector: position and open/close control, no ready or synchrocheck.
// R17 - Earthing switch: position indication only, never commanded.
// R18 - Status flags show open allowed, close allowed, object ready, synchrocheck ok.
// R19 - External object drives ready high when ready and spring charged.
// R20 - Request counters saturate at maximum instead of wrapping.
`ifndef SSM_CONSTS_VH
`define SSM_CONSTS_VH

// Register byte offsets
`define SSM_OFF_CONFIG      8'h00
`define SSM_OFF_CLEAR       8'h04
`define SSM_OFF_STATUS      8'h08
`define SSM_OFF_OPEN_OK     8'h0c
`define SSM_OFF_CLOSE_OK    8'h10
`define SSM_OFF_OPEN_FAIL   8'h14
`define SSM_OFF_CLOSE_FAIL  8'h18

// Configuration fields
`define SSM_CFG_W           6
`define SSM_CFG_RESET       6'h01
`define SSM_CFG_TYPE_LSB    0
`define SSM_CFG_TYPE_MSB    1
`define SSM_CFG_USE_SYNC    2
`define SSM_CFG_SYNC_SRC    3
`define SSM_CFG_RDY_LSB     4
`define SSM_CFG_RDY_MSB     5
`define SSM_CLR_BIT         0

// Status fields
`define SSM_ST_W            9
`define SSM_ST_BRK_LSB      0
`define SSM_ST_BRK_MSB      1
`define SSM_ST_CART_LSB     2
`define SSM_ST_CART_MSB     4
`define SSM_ST_OPEN_OK      5
`define SSM_ST_CLOSE_OK     6
`define SSM_ST_READY        7
`define SSM_ST_SYNC         8

// Object types
`define SSM_TYPE_WD_CB      2'h0
`define SSM_TYPE_CB         2'h1
`define SSM_TYPE_MAIN_DISC  2'h2
`define SSM_TYPE_EARTH      2'h3

// Breaker position codes
`define SSM_BRK_INTER       2'h0
`define SSM_BRK_OPEN        2'h1
`define SSM_BRK_CLOSED      2'h2
`define SSM_BRK_BAD         2'h3

// Cart position codes
`define SSM_CART_MIDWAY     3'h0
`define SSM_CART_WITHDRAWN  3'h1
`define SSM_CART_INSERTED   3'h2
`define SSM_CART_FAULT      3'h3
`define SSM_CART_UNUSED     3'h4

// Ready check modes
`define SSM_RDY_UNUSED      2'h0
`define SSM_RDY_HIGH        2'h1
`define SSM_RDY_LOW         2'h2

// AXI responses
`define SSM_RESP_OKAY       2'h0
`define SSM_RESP_SLVERR     2'h2

`endif

// ### hdl/ssm_monitor.v
// Switchgear object status monitor with AXI4-Lite register access
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "ssm_consts.vh"
module ssm_monitor #(
  parameter CNT_W  = 32,
  parameter ADDR_W = 8
) (
  // Clock and reset
  input  wire              mclk,
  input  wire              rst_n,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  // Field status pins, asynchronous
  input  wire              pin_open_pos,
  input  wire              pin_close_pos,
  input  wire              pin_cart_in,
  input  wire              pin_cart_out,
  input  wire              pin_ready,
  input  wire              pin_ext_sync,
  // Internal logic on mclk
  input  wire              int_sync_ok,
  input  wire              open_ilock,
  input  wire              close_ilock,
  input  wire              open_req,
  input  wire              close_req,
  // Commands
  output wire              open_cmd,
  output wire              close_cmd,
  // Status
  output wire [1:0]        breaker_pos,
  output wire [2:0]        cart_pos,
  output wire              open_allowed,
  output wire              close_allowed,
  output wire              object_ready,
  output wire              sync_ok
);
  localparam NUM_CNT = 4;

  // Synchronised pins
  wire [5:0]             pin_s;
  wire                   open_s;
  wire                   close_s;
  wire                   cart_in_s;
  wire                   cart_out_s;
  wire                   ready_s;
  wire                   ext_sync_s;
  // Configuration and status
  reg  [`SSM_CFG_W-1:0]  cfg_q;
  wire [1:0]             obj_type;
  wire                   use_sync;
  wire                   sync_src;
  wire [1:0]             rdy_mode;
  reg  [1:0]             brk_q;
  reg  [1:0]             brk_d;
  reg  [2:0]             cart_q;
  reg  [2:0]             cart_d;
  reg                    open_ok_q;
  reg                    close_ok_q;
  reg                    ready_ok_q;
  reg                    sync_perm_q;
  reg                    open_ok_d;
  reg                    close_ok_d;
  reg                    ready_ok_d;
  reg                    sync_perm_d;
  reg                    gated_type;
  reg                    open_cmd_q;
  reg                    close_cmd_q;
  // Request outcome
  wire                   open_go;
  wire                   open_bad;
  wire                   close_go;
  wire                   close_bad;
  wire [NUM_CNT-1:0]     cnt_inc;
  wire [NUM_CNT*CNT_W-1:0] cnt_bus;
  reg                    clear_q;
  // Bus state
  reg                    awready_q;
  reg                    wready_q;
  reg                    bvalid_q;
  reg  [1:0]             bresp_q;
  reg                    aw_got_q;
  reg                    w_got_q;
  reg  [ADDR_W-1:0]      waddr_q;
  reg  [31:0]            wdata_q;
  reg  [3:0]             wstrb_q;
  reg                    arready_q;
  reg                    rvalid_q;
  reg  [1:0]             rresp_q;
  reg  [31:0]            rdata_q;
  reg  [31:0]            rd_mux;
  reg                    rd_hit;
  wire [ADDR_W-1:0]      rd_off;
  wire [ADDR_W-1:0]      wr_off;
  wire                   wr_fire;

  assign open_s     = pin_s[0];
  assign close_s    = pin_s[1];
  assign cart_in_s  = pin_s[2];
  assign cart_out_s = pin_s[3];
  assign ready_s    = pin_s[4];
  assign ext_sync_s = pin_s[5];

  ssm_sync2 #(
    .WIDTH (6)
  ) u_pin_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({pin_ext_sync, pin_ready, pin_cart_out, pin_cart_in, pin_close_pos, pin_open_pos}),
    .q     (pin_s)
  );

  assign obj_type = cfg_q[`SSM_CFG_TYPE_MSB:`SSM_CFG_TYPE_LSB];
  assign use_sync = cfg_q[`SSM_CFG_USE_SYNC];
  assign sync_src = cfg_q[`SSM_CFG_SYNC_SRC];
  assign rdy_mode = cfg_q[`SSM_CFG_RDY_MSB:`SSM_CFG_RDY_LSB];

  always @* begin
    // R01 neither active
    brk_d = `SSM_BRK_INTER;
    case ({open_s, close_s})
      // R03 single input
      2'b10: begin
        brk_d = `SSM_BRK_OPEN;
      end
      2'b01: begin
        brk_d = `SSM_BRK_CLOSED;
      end
      // R02 both active
      2'b11: begin
        brk_d = `SSM_BRK_BAD;
      end
      default: begin
        brk_d = `SSM_BRK_INTER;
      end
    endcase

    // R06 cart unused
    cart_d = `SSM_CART_UNUSED;
    // R13 type selects supervision
    if (obj_type == `SSM_TYPE_WD_CB) begin
      case ({cart_in_s, cart_out_s})
        2'b10: begin
          cart_d = `SSM_CART_INSERTED;
        end
        2'b01: begin
          cart_d = `SSM_CART_WITHDRAWN;
        end
        // R05 both cart inputs
        2'b11: begin
          cart_d = `SSM_CART_FAULT;
        end
        // R04 cart midway
        default: begin
          cart_d = `SSM_CART_MIDWAY;
        end
      endcase
    end

    // R08 permission source
    sync_perm_d = sync_src ? ext_sync_s : int_sync_ok;

    // R09 ready level check
    case (rdy_mode)
      `SSM_RDY_HIGH: begin
        ready_ok_d = ready_s;
      end
      `SSM_RDY_LOW: begin
        ready_ok_d = ~ready_s;
      end
      default: begin
        ready_ok_d = 1'b1;
      end
    endcase

    // R14 R15 breaker types gated
    gated_type = (obj_type == `SSM_TYPE_WD_CB) || (obj_type == `SSM_TYPE_CB);

    // R17 earthing never commanded
    open_ok_d = (obj_type != `SSM_TYPE_EARTH) && !(gated_type && open_ilock);
    // R16 disconnector ungated close
    close_ok_d = (obj_type != `SSM_TYPE_EARTH) &&
                 (!gated_type ||
                  // R07 synchrocheck gate
                  (ready_ok_d && (!use_sync || sync_perm_d) && !close_ilock));
  end

  // Open wins when both requests arrive together; the close is then refused
  assign open_go   = open_req & open_ok_d;
  assign open_bad  = open_req & ~open_ok_d;
  assign close_go  = close_req & ~open_req & close_ok_d;
  assign close_bad = close_req & ~(~open_req & close_ok_d);
  assign cnt_inc   = {close_bad, open_bad, close_go, open_go};

  always @(posedge mclk) begin
    if (!rst_n) begin
      brk_q       <= `SSM_BRK_INTER;
      cart_q      <= `SSM_CART_UNUSED;
      open_ok_q   <= 1'b0;
      close_ok_q  <= 1'b0;
      ready_ok_q  <= 1'b0;
      sync_perm_q <= 1'b0;
      open_cmd_q  <= 1'b0;
      close_cmd_q <= 1'b0;
    end else begin
      brk_q       <= brk_d;
      cart_q      <= cart_d;
      // R18 additional flags
      open_ok_q   <= open_ok_d;
      close_ok_q  <= close_ok_d;
      ready_ok_q  <= ready_ok_d;
      sync_perm_q <= sync_perm_d;
      // R17 commands only when allowed
      open_cmd_q  <= open_go;
      close_cmd_q <= close_go;
    end
  end

  // R10 R11 four counters
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi = gi + 1) begin : g_cnt
      ssm_sat_counter #(
        .WIDTH (CNT_W)
      ) u_cnt (
        .mclk  (mclk),
        .rst_n (rst_n),
        .clear (clear_q),
        .inc   (cnt_inc[gi]),
        .count (cnt_bus[gi*CNT_W +: CNT_W])
      );
    end
  endgenerate

  // Write path: address and data are captured independently in any order
  assign wr_off  = {waddr_q[ADDR_W-1:2], 2'b00};
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;

  always @(posedge mclk) begin
    if (!rst_n) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `SSM_RESP_OKAY;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      waddr_q   <= {ADDR_W{1'b0}};
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      cfg_q     <= `SSM_CFG_RESET;
      clear_q   <= 1'b0;
    end else begin
      // R12 self-clearing control
      clear_q <= 1'b0;
      if (!aw_got_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (!w_got_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (s_axi_awvalid && awready_q) begin
        waddr_q   <= s_axi_awaddr;
        aw_got_q  <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_got_q  <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= `SSM_RESP_OKAY;
        case (wr_off)
          `SSM_OFF_CONFIG: begin
            if (wstrb_q[0]) begin
              cfg_q <= wdata_q[`SSM_CFG_W-1:0];
            end
          end
          `SSM_OFF_CLEAR: begin
            // R12 clear all counters
            if (wstrb_q[0] && wdata_q[`SSM_CLR_BIT]) begin
              clear_q <= 1'b1;
            end
          end
          `SSM_OFF_STATUS, `SSM_OFF_OPEN_OK, `SSM_OFF_CLOSE_OK,
          `SSM_OFF_OPEN_FAIL, `SSM_OFF_CLOSE_FAIL: begin
            bresp_q <= `SSM_RESP_OKAY;
          end
          default: begin
            bresp_q <= `SSM_RESP_SLVERR;
          end
        endcase
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read path
  assign rd_off = {s_axi_araddr[ADDR_W-1:2], 2'b00};

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (rd_off)
      `SSM_OFF_CONFIG: begin
        rd_mux[`SSM_CFG_W-1:0] = cfg_q;
      end
      `SSM_OFF_CLEAR: begin
        rd_mux = 32'h0000_0000;
      end
      `SSM_OFF_STATUS: begin
        rd_mux[`SSM_ST_BRK_MSB:`SSM_ST_BRK_LSB]   = brk_q;
        rd_mux[`SSM_ST_CART_MSB:`SSM_ST_CART_LSB] = cart_q;
        rd_mux[`SSM_ST_OPEN_OK]                   = open_ok_q;
        rd_mux[`SSM_ST_CLOSE_OK]                  = close_ok_q;
        rd_mux[`SSM_ST_READY]                     = ready_ok_q;
        rd_mux[`SSM_ST_SYNC]                      = sync_perm_q;
      end
      `SSM_OFF_OPEN_OK: begin
        rd_mux = cnt_bus[0*CNT_W +: 32];
      end
      `SSM_OFF_CLOSE_OK: begin
        rd_mux = cnt_bus[1*CNT_W +: 32];
      end
      `SSM_OFF_OPEN_FAIL: begin
        rd_mux = cnt_bus[2*CNT_W +: 32];
      end
      `SSM_OFF_CLOSE_FAIL: begin
        rd_mux = cnt_bus[3*CNT_W +: 32];
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= `SSM_RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_mux;
        rresp_q   <= rd_hit ? `SSM_RESP_OKAY : `SSM_RESP_SLVERR;
      end
      if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign open_cmd      = open_cmd_q;
  assign close_cmd     = close_cmd_q;
  assign breaker_pos   = brk_q;
  assign cart_pos      = cart_q;
  assign open_allowed  = open_ok_q;
  assign close_allowed = close_ok_q;
  assign object_ready  = ready_ok_q;
  assign sync_ok       = sync_perm_q;
endmodule // ssm_monitor

// ### hdl/ssm_sat_counter.v
// Saturating request counter with synchronous clear
`timescale 1ns/100ps
module ssm_sat_counter #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rst_n,
  // Control
  input  wire             clear,
  input  wire             inc,
  // Count
  output wire [WIDTH-1:0] count
);
  localparam [WIDTH-1:0] MAX_COUNT = {WIDTH{1'b1}};
  localparam [WIDTH-1:0] ONE       = {{(WIDTH-1){1'b0}}, 1'b1};

  reg [WIDTH-1:0] count_q;
  reg [WIDTH-1:0] count_d;

  always @* begin
    count_d = count_q;
    // R12 clear to zero
    if (clear) begin
      // An event in the clearing cycle is kept
      count_d = inc ? ONE : {WIDTH{1'b0}};
    // R20 hold at maximum
    end else if (inc && (count_q != MAX_COUNT)) begin
      count_d = count_q + ONE;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      count_q <= {WIDTH{1'b0}};
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;
endmodule // ssm_sat_counter

// ### hdl/ssm_sync2.v
// Two-stage synchroniser for asynchronous status pins
`timescale 1ns/100ps
module ssm_sync2 #(
  parameter WIDTH = 6
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rst_n,
  // Data
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // ssm_sync2

// ### verification/ssm_contacts.sv
// Behavioural auxiliary contacts of the switching object
`timescale 1ns/100ps
module ssm_contacts #(
  parameter TRAVEL = 7
) (
  // Wanted state from the bench
  input  wire [1:0] brk_state,
  input  wire [1:0] cart_state,
  input  wire       spring_ok,
  input  wire       sync_perm,
  // Contact pins
  output reg        pin_open_pos,
  output reg        pin_close_pos,
  output wire       pin_cart_in,
  output wire       pin_cart_out,
  output wire       pin_ready,
  output wire       pin_ext_sync
);
  initial {pin_close_pos, pin_open_pos} = 2'h0;
  // Both contacts drop while the main contacts travel
  always @(brk_state) begin
    {pin_close_pos, pin_open_pos} = 2'h0;
    #TRAVEL {pin_close_pos, pin_open_pos} = brk_state;
  end
  assign #TRAVEL {pin_cart_in, pin_cart_out} = cart_state;
  assign #TRAVEL pin_ready = spring_ok;
  assign #TRAVEL pin_ext_sync = sync_perm;
endmodule // ssm_contacts

// ### verification/ssm_monitor_props.sv
// Port-level assertions for the switchgear status monitor
`timescale 1ns/100ps
module ssm_monitor_props (
  // Clock and reset
  input wire       mclk,
  input wire       rst_n,
  // Contacts and requests
  input wire       pin_open_pos,
  input wire       pin_close_pos,
  input wire       pin_cart_in,
  input wire       pin_cart_out,
  input wire       open_req,
  input wire       close_req,
  // Results
  input wire       open_cmd,
  input wire       close_cmd,
  input wire [1:0] breaker_pos,
  input wire [2:0] cart_pos
);
  wire [1:0] brk = {pin_close_pos, pin_open_pos};
  wire [1:0] crt = {pin_cart_in, pin_cart_out};

  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Two sync stages plus the status register: four stable samples suffice
  brk_inter_a: assert property ((brk == 2'h0)[*4] |-> breaker_pos == 2'h0)
    else $error("breaker not intermediate");
  brk_bad_a: assert property ((brk == 2'h3)[*4] |-> breaker_pos == 2'h3)
    else $error("breaker not bad");
  brk_open_a: assert property ((brk == 2'h1)[*4] |-> breaker_pos == 2'h1)
    else $error("breaker not open");
  brk_closed_a: assert property ((brk == 2'h2)[*4] |-> breaker_pos == 2'h2)
    else $error("breaker not closed");
  // Cart may read not in use when the object type has no cart
  cart_midway_a: assert property ((crt == 2'h0)[*4] |-> cart_pos inside {3'h0, 3'h4})
    else $error("cart not midway");
  cart_fault_a: assert property ((crt == 2'h3)[*4] |-> cart_pos inside {3'h3, 3'h4})
    else $error("cart not faulty");
  open_cause_a: assert property (open_cmd |-> $past(open_req))
    else $error("open command without request");
  close_cause_a: assert property (close_cmd |-> $past(close_req) && !$past(open_req))
    else $error("close command without sole request");
  cmd_excl_a: assert property (!(open_cmd && close_cmd))
    else $error("open and close together");

  cover property (open_cmd);
  cover property (close_cmd);
  cover property (breaker_pos == 2'h3);
endmodule // ssm_monitor_props

// ### verification/testbench.sv
// Self-checking bench for the switchgear status monitor
`timescale 1ns/100ps
`include "ssm_consts.vh"
module testbench;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        int_sync_ok = 1'b0;
  logic        open_ilock = 1'b0;
  logic        close_ilock = 1'b0;
  logic        open_req = 1'b0;
  logic        close_req = 1'b0;
  logic [1:0]  brk_state = 2'h0;
  logic [1:0]  cart_state = 2'h0;
  logic        spring_ok = 1'b0;
  logic        sync_perm = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid, open_cmd, close_cmd;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire         p_open, p_close, p_in, p_out, p_rdy, p_sync;
  wire         o_al, c_al, o_rdy, s_ok;
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [31:0] cnt [4] = '{default: 32'h0};
  logic [31:0] rv;
  logic [1:0]  rr;

  ssm_monitor #(.CNT_W(32), .ADDR_W(8)) dut (
    .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_open_pos(p_open), .pin_close_pos(p_close),
    .pin_cart_in(p_in), .pin_cart_out(p_out), .pin_ready(p_rdy), .pin_ext_sync(p_sync),
    .int_sync_ok(int_sync_ok), .open_ilock(open_ilock), .close_ilock(close_ilock), .open_req(open_req),
    .close_req(close_req), .open_cmd(open_cmd), .close_cmd(close_cmd), .breaker_pos(), .cart_pos(),
    .open_allowed(o_al), .close_allowed(c_al), .object_ready(o_rdy), .sync_ok(s_ok));

  ssm_contacts field (
    .brk_state(brk_state), .cart_state(cart_state), .spring_ok(spring_ok), .sync_perm(sync_perm),
    .pin_open_pos(p_open), .pin_close_pos(p_close), .pin_cart_in(p_in), .pin_cart_out(p_out),
    .pin_ready(p_rdy), .pin_ext_sync(p_sync));

  initial forever #2 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      #1;
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rr = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk({30'h0, rr}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    logic ta, tr;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      #1;
      ta = arvalid && arready;
      tr = rvalid;
      rv = rdata;
      rr = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk({30'h0, rr}, {30'h0, er});
  endtask

  // Counter index: open ok, close ok, open failed, close failed
  task automatic req(input logic cls, input logic ok);
    @(posedge mclk);
    if (cls) close_req <= 1'b1;
    else open_req <= 1'b1;
    @(posedge mclk);
    close_req <= 1'b0;
    open_req  <= 1'b0;
    #1;
    chk({31'h0, cls ? close_cmd : open_cmd}, {31'h0, ok});
    chk({31'h0, cls ? c_al : o_al}, {31'h0, ok});
    cnt[cls + (ok ? 0 : 2)]++;
    // Hand back on an edge so the caller drives by non-blocking assignment there
    @(posedge mclk);
  endtask

  task automatic close_case(input logic [31:0] cfg, input logic [3:0] cond, input logic ok);
    logic [1:0] rm;
    rm = cfg[`SSM_CFG_RDY_MSB:`SSM_CFG_RDY_LSB];
    wr(`SSM_OFF_CONFIG, cfg, `SSM_RESP_OKAY);
    {spring_ok, int_sync_ok, sync_perm, close_ilock} <= cond;
    repeat (8) @(posedge mclk);
    rd(`SSM_OFF_STATUS, `SSM_RESP_OKAY);
    chk({31'h0, rv[`SSM_ST_CLOSE_OK]}, {31'h0, ok});
    chk({31'h0, o_rdy}, {31'h0, (rm == `SSM_RDY_HIGH) ? cond[3] : (rm == `SSM_RDY_LOW) ? !cond[3] : 1'b1});
    chk({31'h0, s_ok}, {31'h0, cfg[`SSM_CFG_SYNC_SRC] ? cond[1] : cond[2]});
    req(1'b1, ok);
  endtask

  task automatic t_reset();
    rd(`SSM_OFF_CONFIG, `SSM_RESP_OKAY);
    chk(rv, {26'h0, `SSM_CFG_RESET});
    rd(8'h40, `SSM_RESP_SLVERR);
    chk(rv, 32'h0);
    rd(`SSM_OFF_STATUS, `SSM_RESP_OKAY);
    chk({29'h0, rv[`SSM_ST_CART_MSB:`SSM_ST_CART_LSB]}, {29'h0, `SSM_CART_UNUSED});
  endtask

  task automatic t_positions();
    for (int i = 0; i < 4; i++) begin
      brk_state  <= 2'(i);
      cart_state <= 2'(i);
      wr(`SSM_OFF_CONFIG, 32'h0, `SSM_RESP_OKAY);
      repeat (8) @(posedge mclk);
      rd(`SSM_OFF_STATUS, `SSM_RESP_OKAY);
      chk({30'h0, rv[`SSM_ST_BRK_MSB:`SSM_ST_BRK_LSB]}, 32'(i));
      chk({29'h0, rv[`SSM_ST_CART_MSB:`SSM_ST_CART_LSB]}, 32'(i));
      wr(`SSM_OFF_CONFIG, 32'h1, `SSM_RESP_OKAY);
      repeat (4) @(posedge mclk);
      rd(`SSM_OFF_STATUS, `SSM_RESP_OKAY);
      chk({29'h0, rv[`SSM_ST_CART_MSB:`SSM_ST_CART_LSB]}, {29'h0, `SSM_CART_UNUSED});
    end
  endtask

  // Condition order: ready pin, internal sync, external sync, close interlock
  task automatic t_gates();
    close_case(32'h11, 4'b0000, 1'b0);
    close_case(32'h11, 4'b1000, 1'b1);
    close_case(32'h21, 4'b1000, 1'b0);
    close_case(32'h21, 4'b0000, 1'b1);
    close_case(32'h01, 4'b0000, 1'b1);
    close_case(32'h05, 4'b0010, 1'b0);
    close_case(32'h05, 4'b0100, 1'b1);
    close_case(32'h0d, 4'b0100, 1'b0);
    close_case(32'h0d, 4'b0010, 1'b1);
    close_case(32'h01, 4'b0001, 1'b0);
    close_case(32'h00, 4'b0000, 1'b1);
    close_case(32'h16, 4'b0001, 1'b1);
    close_case(32'h03, 4'b1110, 1'b0);
    req(1'b0, 1'b0);
  endtask

  task automatic t_open();
    open_ilock <= 1'b1;
    wr(`SSM_OFF_CONFIG, 32'h2, `SSM_RESP_OKAY);
    repeat (2) @(posedge mclk);
    req(1'b0, 1'b1);
    wr(`SSM_OFF_CONFIG, 32'h1, `SSM_RESP_OKAY);
    repeat (2) @(posedge mclk);
    req(1'b0, 1'b0);
    open_ilock <= 1'b0;
    req(1'b0, 1'b1);
    req(1'b0, 1'b1);
  endtask

  task automatic t_counts();
    for (int i = 0; i < 4; i++) begin
      rd(8'h0c + 8'(4 * i), `SSM_RESP_OKAY);
      chk(rv, cnt[i]);
    end
    wr(`SSM_OFF_CLEAR, 32'h1, `SSM_RESP_OKAY);
    wr(8'h40, 32'h3, `SSM_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      rd(8'h0c + 8'(4 * i), `SSM_RESP_OKAY);
      chk(rv, 32'h0);
    end
    rd(`SSM_OFF_CLEAR, `SSM_RESP_OKAY);
    chk(rv, 32'h0);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_positions();
    t_gates();
    t_open();
    t_counts();
    tally_and_finish();
  end
endmodule // testbench

bind ssm_monitor ssm_monitor_props u_props (
  .mclk(mclk), .rst_n(rst_n), .pin_open_pos(pin_open_pos), .pin_close_pos(pin_close_pos),
  .pin_cart_in(pin_cart_in), .pin_cart_out(pin_cart_out), .open_req(open_req), .close_req(close_req),
  .open_cmd(open_cmd), .close_cmd(close_cmd), .breaker_pos(breaker_pos), .cart_pos(cart_pos));
